/* File: rtl/asgp_pkg.sv */
// Constants, carriers and decode helpers for the analog-shared GPIO port
package asgp_pkg;

    // Widths
    localparam int PIN_W  = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CFG_W  = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_DATA   = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 8'h85;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 8'h9f;
    localparam logic [ADDR_W-1:0] OFS_PIN_SET    = 8'he5;
    localparam logic [ADDR_W-1:0] OFS_PIN_CLR    = 8'he6;

    // Pin roles and field positions
    localparam int TMR_PIN    = 4;
    localparam int SS_PIN     = 5;
    localparam int VREF_PIN   = 3;
    localparam int RESFMT_BIT = 7;
    localparam int CFG_LSB    = 0;

    // Reset values
    localparam logic [PIN_W-1:0] LATCH_RST = 6'h00;
    localparam logic [PIN_W-1:0] DIR_RST   = 6'h3f;
    localparam logic [CFG_W-1:0] CFG_RST   = 4'h0;
    localparam logic             FMT_RST   = 1'b0;

    // Pin masks
    localparam logic [PIN_W-1:0] ANALOG_CAPABLE = 6'h2f;
    localparam logic [PIN_W-1:0] NO_MASK        = 6'h00;

    // Software-visible port state
    typedef struct packed {
        logic [PIN_W-1:0] latch;
        logic [PIN_W-1:0] dir;
        logic             fmt;
        logic [CFG_W-1:0] cfg;
    } asgp_regs_t;

    // Whole state of the port module
    typedef struct packed {
        asgp_regs_t        regs;
        logic [DATA_W-1:0] rdata;
        logic [PIN_W-1:0]  pin_out;
        logic [PIN_W-1:0]  pin_oe;
        logic [PIN_W-1:0]  analog;
        logic              vref;
        logic              tmr_clk;
        logic              ss_n;
    } asgp_state_t;

    // Synchroniser state
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] level;
    } asgp_sync_t;

    // Which pins a configuration code turns analog
    function automatic logic [PIN_W-1:0] asgp_analog_mask(input logic [CFG_W-1:0] cfg);
        logic [PIN_W-1:0] m;
        m = ANALOG_CAPABLE;
        case (cfg)
            4'h4, 4'h5: m = 6'h0b;
            4'h6, 4'h7: m = NO_MASK;
            4'hd:       m = 6'h0f;
            4'he:       m = 6'h01;
            4'hf:       m = 6'h0d;
            default:    m = ANALOG_CAPABLE;
        endcase
        return m;
    endfunction

    // Whether a configuration code takes the reference from its pin
    function automatic logic asgp_vref_en(input logic [CFG_W-1:0] cfg);
        return (cfg == 4'h1) || (cfg == 4'h5) || (cfg == 4'hf);
    endfunction

endpackage

/* File: rtl/asgp_port.sv */
// Six-pin GPIO port shared with analog inputs, timer clock and slave select
//
// Contract
// - Six bidirectional pins, each with its own latch bit and direction bit.
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero drives the pin from its latch bit.
// - Data reads return pin levels; data writes go to the latch only.
// - Set and clear writes are read-modify-write: pins sampled, bits changed, whole latch stored.
// - Pin four feeds the timer clock; its output is open drain.
// - Pins other than four may be analog, chosen by the config field.
// - After power-on the analog pins are analog and read as zero.
// - Direction bits still steer drivers while a pin is analog.
// - Unimplemented data, direction and config bits read as zero.
// - Power-on clears latch; other resets keep bit four, clear the rest.
// - Every reset sets all six direction bits.
// - Pin five also serves as serial-port slave select input.
// - Pin three may be GPIO, analog input or reference input.
// - An enabled peripheral on a pin takes it away from GPIO.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module asgp_port
    import asgp_pkg::*;
(
    // Clock and resets
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_other_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // Pins
    input  wire logic [PIN_W-1:0]  i_pin_in,
    output logic      [PIN_W-1:0]  o_pin_out,
    output logic      [PIN_W-1:0]  o_pin_oe,
    // Peripheral enables
    input  wire logic              i_tmr_ext_en,
    input  wire logic              i_ss_en,
    // Peripheral and analog side
    output logic                   o_tmr_clk,
    output logic                   o_slave_select_n,
    output logic      [PIN_W-1:0]  o_analog_sel,
    output logic                   o_vref_sel,
    output logic                   o_result_format
);

    asgp_state_t      st_q;
    asgp_state_t      st_d;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] digital_in;

    // Pin levels into the core clock domain
    asgp_sync u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_pin_in),
        .o_level  (pin_lvl)
    );

    // Analog pins read as zero on the digital path
    assign digital_in = pin_lvl & ~asgp_analog_mask(st_q.regs.cfg);

    // Next-state logic: register access, other reset, pin drivers
    always_comb begin
        st_d       = st_q;
        st_d.rdata = '0;

        // Read data stands for the one cycle after the strobe
        if (i_rd) begin
            case (i_addr)
                OFS_PIN_DATA:   st_d.rdata = {2'b00, digital_in};
                OFS_DIRECTION:  st_d.rdata = {2'b00, st_q.regs.dir};
                OFS_ANALOG_CFG: st_d.rdata = {st_q.regs.fmt, 3'b000, st_q.regs.cfg};
                default:        st_d.rdata = '0;
            endcase
        end

        // Data writes load the latch; set and clear build it from sampled pins; direction and config writes load their fields
        if (i_wr) begin
            case (i_addr)
                OFS_PIN_DATA: begin
                    st_d.regs.latch = i_wdata[PIN_W-1:0];
                end
                OFS_PIN_SET: begin
                    st_d.regs.latch = digital_in | i_wdata[PIN_W-1:0];
                end
                OFS_PIN_CLR: begin
                    st_d.regs.latch = digital_in & ~i_wdata[PIN_W-1:0];
                end
                OFS_DIRECTION: begin
                    st_d.regs.dir = i_wdata[PIN_W-1:0];
                end
                OFS_ANALOG_CFG: begin
                    st_d.regs.fmt = i_wdata[RESFMT_BIT];
                    st_d.regs.cfg = i_wdata[CFG_LSB +: CFG_W];
                end
                default: begin
                    st_d.regs = st_q.regs;
                end
            endcase
        end

        // Non-power resets win over a write in the same cycle
        if (i_other_rst) begin
            st_d.regs.latch          = LATCH_RST;
            st_d.regs.latch[TMR_PIN] = st_q.regs.latch[TMR_PIN];
            st_d.regs.dir            = DIR_RST;
            st_d.regs.fmt            = FMT_RST;
            st_d.regs.cfg            = CFG_RST;
        end

        // Push-pull drivers gated by direction, on every pin but the timer pin
        st_d.pin_out = st_d.regs.latch;
        st_d.pin_oe  = ~st_d.regs.dir;

        // Timer clock pin: open drain, only pulls low
        st_d.pin_out[TMR_PIN] = 1'b0;
        st_d.pin_oe[TMR_PIN]  = ~st_d.regs.dir[TMR_PIN] & ~st_d.regs.latch[TMR_PIN]
                                & ~i_tmr_ext_en;

        // Slave select in use keeps its pin receive-only
        if (i_ss_en) begin
            st_d.pin_oe[SS_PIN] = 1'b0;
        end

        // Analog routing and peripheral inputs
        st_d.analog  = asgp_analog_mask(st_d.regs.cfg);
        st_d.vref    = asgp_vref_en(st_d.regs.cfg);
        st_d.tmr_clk = pin_lvl[TMR_PIN];
        st_d.ss_n    = pin_lvl[SS_PIN] | ~i_ss_en;
    end

    // State register; power-on leaves all pins inputs, all but pin four analog
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q.regs.latch <= LATCH_RST;
            st_q.regs.dir   <= DIR_RST;
            st_q.regs.fmt   <= FMT_RST;
            st_q.regs.cfg   <= CFG_RST;
            st_q.rdata      <= '0;
            st_q.pin_out    <= '0;
            st_q.pin_oe     <= '0;
            st_q.analog     <= ANALOG_CAPABLE;
            st_q.vref       <= 1'b0;
            st_q.tmr_clk    <= 1'b1; // Idle high like the pulled-up pin
            st_q.ss_n       <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign o_rdata          = st_q.rdata;
    assign o_pin_out        = st_q.pin_out;
    assign o_pin_oe         = st_q.pin_oe;
    assign o_tmr_clk        = st_q.tmr_clk;
    assign o_slave_select_n = st_q.ss_n;
    assign o_analog_sel     = st_q.analog;
    assign o_vref_sel       = st_q.vref;
    assign o_result_format  = st_q.regs.fmt;

    // Checks on the port behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Data read returns synchronised digital pin levels
    pin_read_a: assert property (
        (i_rd && i_addr == OFS_PIN_DATA) |=> (o_rdata == {2'b00, $past(digital_in)})
    ) else $error("pin data read mismatch");

    // Read data lasts one cycle only
    rdata_pulse_a: assert property (
        (!i_rd) |=> (o_rdata == '0)
    ) else $error("read data outside read slot");

    // Plain data write lands in the latch
    latch_write_a: assert property (
        (i_wr && i_addr == OFS_PIN_DATA && !i_other_rst)
        |=> (st_q.regs.latch == $past(i_wdata[PIN_W-1:0]))
    ) else $error("latch write lost");

    // Set and clear writes merge into sampled pins
    rmw_merge_a: assert property (
        (i_wr && i_addr == OFS_PIN_SET && !i_other_rst)
        |=> (st_q.regs.latch == ($past(digital_in) | $past(i_wdata[PIN_W-1:0])))
    ) else $error("set write did not merge pins");

    rmw_clear_a: assert property (
        (i_wr && i_addr == OFS_PIN_CLR && !i_other_rst)
        |=> (st_q.regs.latch == ($past(digital_in) & ~$past(i_wdata[PIN_W-1:0])))
    ) else $error("clear write did not merge pins");

    // Input direction never drives
    input_hiz_a: assert property (
        (o_pin_oe & st_q.regs.dir) == '0
    ) else $error("driver on for input pin");

    // Output direction drives the latch on push-pull pins
    output_drive_a: assert property (
        ((~st_q.regs.dir & 6'h0f) == (o_pin_oe & 6'h0f))
        && ((o_pin_out & 6'h2f) == (st_q.regs.latch & 6'h2f))
    ) else $error("push-pull pin not driving latch");

    // Timer pin only ever pulls low
    open_drain_a: assert property (
        (o_pin_out[TMR_PIN] == 1'b0) && !(o_pin_oe[TMR_PIN] && st_q.regs.latch[TMR_PIN])
    ) else $error("timer pin drove high");

    // Timer pin never analog, analog map follows config
    analog_map_a: assert property (
        (o_analog_sel[TMR_PIN] == 1'b0)
        && (o_analog_sel == asgp_analog_mask(st_q.regs.cfg))
    ) else $error("analog selection wrong");

    // Analog pins read as zero
    analog_zero_a: assert property (
        (i_rd && i_addr == OFS_PIN_DATA && st_q.regs.cfg == CFG_RST)
        |=> (o_rdata[5] == 1'b0 && o_rdata[3:0] == 4'h0)
    ) else $error("analog pin read nonzero");

    // Analog pin with direction cleared still drives
    analog_drive_a: assert property (
        (st_q.analog[0] && !st_q.regs.dir[0]) |-> o_pin_oe[0]
    ) else $error("direction ignored on analog pin");

    // Unimplemented data and direction bits read zero
    unimpl_zero_a: assert property (
        (i_rd && (i_addr == OFS_PIN_DATA || i_addr == OFS_DIRECTION))
        |=> (o_rdata[7:6] == 2'b00)
    ) else $error("unimplemented bits read nonzero");

    // Unimplemented config bits read zero
    cfg_unimpl_a: assert property (
        (i_rd && i_addr == OFS_ANALOG_CFG) |=> (o_rdata[6:4] == 3'b000)
    ) else $error("unimplemented config bits read nonzero");

    // Other reset keeps bit four and sets all inputs
    other_reset_a: assert property (
        i_other_rst |=> (st_q.regs.dir == DIR_RST)
                        && (st_q.regs.latch[TMR_PIN] == $past(st_q.regs.latch[TMR_PIN]))
                        && ((st_q.regs.latch & 6'h2f) == 6'h00)
                        && (st_q.regs.cfg == CFG_RST)
    ) else $error("other reset values wrong");

    // Slave select enabled keeps its pin undriven
    slave_select_a: assert property (
        $past(i_ss_en) |-> (!o_pin_oe[SS_PIN])
    ) else $error("slave select pin driven");

    // Reference select follows config
    vref_sel_a: assert property (
        o_vref_sel == asgp_vref_en(st_q.regs.cfg)
    ) else $error("reference select wrong");

    // Direction read returns the direction bits
    dir_read_a: assert property (
        (i_rd && i_addr == OFS_DIRECTION)
        |=> (o_rdata[PIN_W-1:0] == $past(st_q.regs.dir))
    ) else $error("direction read mismatch");

    // Config read returns format bit and field
    cfg_read_a: assert property (
        (i_rd && i_addr == OFS_ANALOG_CFG)
        |=> (o_rdata == {$past(st_q.regs.fmt), 3'b000, $past(st_q.regs.cfg)})
    ) else $error("config read mismatch");

    // Reads of unmapped offsets give zero
    unmapped_read_a: assert property (
        (i_rd && i_addr != OFS_PIN_DATA && i_addr != OFS_DIRECTION
         && i_addr != OFS_ANALOG_CFG)
        |=> (o_rdata == '0)
    ) else $error("unmapped read nonzero");

    // Direction write lands
    dir_write_a: assert property (
        (i_wr && i_addr == OFS_DIRECTION && !i_other_rst)
        |=> (st_q.regs.dir == $past(i_wdata[PIN_W-1:0]))
    ) else $error("direction write lost");

    // Config write lands in format bit and field
    cfg_write_a: assert property (
        (i_wr && i_addr == OFS_ANALOG_CFG && !i_other_rst)
        |=> (st_q.regs.fmt == $past(i_wdata[RESFMT_BIT]))
            && (st_q.regs.cfg == $past(i_wdata[CFG_LSB +: CFG_W]))
    ) else $error("config write lost");

    // Writes to unmapped offsets change nothing
    unmapped_write_a: assert property (
        (i_wr && !i_other_rst && i_addr != OFS_PIN_DATA && i_addr != OFS_DIRECTION
         && i_addr != OFS_ANALOG_CFG && i_addr != OFS_PIN_SET && i_addr != OFS_PIN_CLR)
        |=> $stable(st_q.regs)
    ) else $error("unmapped write changed state");

    // Registers hold without a write or reset
    regs_hold_a: assert property (
        (!i_wr && !i_other_rst) |=> $stable(st_q.regs)
    ) else $error("registers changed without write");

    // Data writes leave direction and config alone
    data_only_a: assert property (
        (i_wr && !i_other_rst
         && (i_addr == OFS_PIN_DATA || i_addr == OFS_PIN_SET || i_addr == OFS_PIN_CLR))
        |=> $stable(st_q.regs.dir) && $stable(st_q.regs.cfg) && $stable(st_q.regs.fmt)
    ) else $error("data write touched other registers");

    // Timer clock input in use releases its pin
    tmr_oe_a: assert property (
        i_tmr_ext_en |=> !o_pin_oe[TMR_PIN]
    ) else $error("timer pin driven while clock input in use");

    // Timer clock follows the synchronised pin
    tmr_clk_a: assert property (
        o_tmr_clk == $past(pin_lvl[TMR_PIN])
    ) else $error("timer clock not following pin");

    // Slave select follows its pin while enabled, idle otherwise
    ss_level_a: assert property (
        o_slave_select_n == ($past(pin_lvl[SS_PIN]) | !$past(i_ss_en))
    ) else $error("slave select level wrong");

    // Analog pins never leak into a data read
    analog_read_a: assert property (
        (i_rd && i_addr == OFS_PIN_DATA)
        |=> ((o_rdata[PIN_W-1:0] & $past(st_q.analog)) == '0)
    ) else $error("analog pin leaked into read");

    // Reference input implies its pin is analog
    vref_analog_a: assert property (
        o_vref_sel |-> o_analog_sel[VREF_PIN]
    ) else $error("reference pin left digital");

    // Other reset clears the format bit
    other_fmt_a: assert property (
        i_other_rst |=> !o_result_format
    ) else $error("format bit survived reset");

    // Other reset turns every pin into an input
    other_oe_a: assert property (
        i_other_rst |=> (o_pin_oe == '0)
    ) else $error("driver on after reset");

endmodule

/* File: rtl/asgp_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module asgp_sync
    import asgp_pkg::*;
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Asynchronous pins in, filtered levels out
    input  wire logic [PIN_W-1:0] i_async,
    output logic      [PIN_W-1:0] o_level
);

    asgp_sync_t st_q;
    asgp_sync_t st_d;

    // Shift chain; level moves only once stages two and three agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < PIN_W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.level[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '1; // Idle high, so no false timer edge after reset
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.level;

endmodule

/* File: tb/asgp_board.sv */
// Board model: external drivers and the pull-up on the timer pin
`timescale 1ns/1ps
module asgp_board
    import asgp_pkg::*;
(
    // Clock
    input  wire logic             i_clk,
    // Design pin drive
    input  wire logic [PIN_W-1:0] i_pin_out,
    input  wire logic [PIN_W-1:0] i_pin_oe,
    // Board drivers commanded by the bench
    input  wire logic [PIN_W-1:0] i_drv_val,
    input  wire logic [PIN_W-1:0] i_drv_en,
    // Resolved pin levels
    output logic      [PIN_W-1:0] o_pin_in
);
    logic [PIN_W-1:0] float_q = 6'h15;

    // Undriven pins without pull-up wander every cycle
    always @(posedge i_clk) begin
        float_q <= ~float_q;
    end

    // Wire level from all drivers; design drive wins
    always_comb begin
        for (int b = 0; b < PIN_W; b++) begin
            if (i_pin_oe[b]) begin
                o_pin_in[b] = i_pin_out[b];
            end else if (i_drv_en[b]) begin
                o_pin_in[b] = i_drv_val[b];
            end else if (b == TMR_PIN) begin
                o_pin_in[b] = 1'b1;
            end else begin
                o_pin_in[b] = float_q[b];
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the analog-shared GPIO port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top
    import asgp_pkg::*;
;
    logic              clk       = 1'b0;
    logic              resetn    = 1'b0;
    logic              other_rst = 1'b0;
    logic [ADDR_W-1:0] addr      = 8'h00;
    logic [DATA_W-1:0] wdata     = 8'h00;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic              tmr_en    = 1'b0;
    logic              ss_en     = 1'b0;
    logic [PIN_W-1:0]  drv_val   = 6'h3f;
    logic [PIN_W-1:0]  drv_en    = 6'h3f;
    logic [DATA_W-1:0] rdata;
    logic [PIN_W-1:0]  pin_in;
    logic [PIN_W-1:0]  pin_out;
    logic [PIN_W-1:0]  pin_oe;
    logic [PIN_W-1:0]  ana_sel;
    logic              tmr_clk;
    logic              ss_n;
    logic              vref;
    logic              fmt;
    int                errors    = 0;
    int                checks    = 0;

    // 10 MHz core clock
    always #50 clk = ~clk;

    asgp_port DUT (.i_clk(clk), .i_resetn(resetn), .i_other_rst(other_rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .i_tmr_ext_en(tmr_en), .i_ss_en(ss_en), .o_tmr_clk(tmr_clk),
        .o_slave_select_n(ss_n), .o_analog_sel(ana_sel), .o_vref_sel(vref),
        .o_result_format(fmt));

    asgp_board board_model (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .i_drv_val(drv_val), .i_drv_en(drv_en), .o_pin_in(pin_in));

    // Expected analog pins per configuration code
    function automatic logic [PIN_W-1:0] exp_mask(input logic [3:0] c);
        case (c)
            4'h4, 4'h5: return 6'h0b;
            4'h6, 4'h7: return 6'h00;
            4'hd:       return 6'h0f;
            4'he:       return 6'h01;
            4'hf:       return 6'h0d;
            default:    return 6'h2f;
        endcase
    endfunction

    // One-cycle register write
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read, data compared in the following cycle
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    // Let pins pass the synchroniser
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Board drivers
    task automatic board(input logic [PIN_W-1:0] v, input logic [PIN_W-1:0] e);
        @(posedge clk);
        drv_val <= v;
        drv_en  <= e;
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        settle();
        `CHK("oe after reset", 6'h00, pin_oe)
        `CHK("analog after reset", 6'h2f, ana_sel)
        rd_chk("dir reset", OFS_DIRECTION, 8'h3f);
        rd_chk("cfg reset", OFS_ANALOG_CFG, 8'h00);
        rd_chk("analog pins read", OFS_PIN_DATA, 8'h10);
        done("reset");
        for (int c = 0; c < 16; c++) begin
            wr_reg(OFS_ANALOG_CFG, {4'h0, c[3:0]});
            #1;
            `CHK("analog sel", exp_mask(c[3:0]), ana_sel)
            `CHK("vref sel", (c == 1 || c == 5 || c == 15), vref)
        end
        wr_reg(OFS_ANALOG_CFG, 8'hff);
        #1;
        `CHK("format bit", 1'b1, fmt)
        rd_chk("cfg unused bits", OFS_ANALOG_CFG, 8'h8f);
        wr_reg(OFS_DIRECTION, 8'hc0);
        rd_chk("dir unused bits", OFS_DIRECTION, 8'h00);
        `CHK("power-on latch", 6'h3f, pin_oe)
        wr_reg(8'h40, 8'hff);
        rd_chk("unmapped", 8'h40, 8'h00);
        rd_chk("dir untouched", OFS_DIRECTION, 8'h00);
        done("registers");
        wr_reg(OFS_ANALOG_CFG, 8'h06);
        board(6'h00, 6'h00);
        wr_reg(OFS_PIN_DATA, 8'hff);
        settle();
        `CHK("oe latch ones", 6'h2f, pin_oe)
        `CHK("out latch ones", 6'h2f, pin_out)
        rd_chk("pins high", OFS_PIN_DATA, 8'h3f);
        wr_reg(OFS_PIN_DATA, 8'h00);
        settle();
        `CHK("oe latch zeros", 6'h3f, pin_oe)
        rd_chk("pins low", OFS_PIN_DATA, 8'h00);
        wr_reg(OFS_DIRECTION, 8'h3f);
        board(6'h15, 6'h3f);
        wr_reg(OFS_PIN_DATA, 8'h2a);
        settle();
        `CHK("inputs released", 6'h00, pin_oe)
        rd_chk("pins not latch", OFS_PIN_DATA, 8'h15);
        wr_reg(OFS_DIRECTION, 8'h00);
        settle();
        `CHK("latch kept", 6'h2a, pin_out)
        done("drive");
        wr_reg(OFS_DIRECTION, 8'h3f);
        board(6'h01, 6'h3f);
        settle();
        wr_reg(OFS_PIN_SET, 8'h02);
        wr_reg(OFS_DIRECTION, 8'h00);
        settle();
        `CHK("set from pins", 6'h03, pin_out)
        wr_reg(OFS_PIN_CLR, 8'h01);
        settle();
        `CHK("clear from pins", 6'h02, pin_out)
        wr_reg(OFS_ANALOG_CFG, 8'h00);
        settle();
        `CHK("dir rules analog", 6'h3f, pin_oe)
        done("read-modify-write");
        wr_reg(OFS_ANALOG_CFG, 8'h06);
        @(posedge clk);
        ss_en  <= 1'b1;
        tmr_en <= 1'b1;
        board(6'h10, 6'h3f);
        settle();
        `CHK("peripheral pins off", 6'h0f, pin_oe)
        `CHK("slave select low", 1'b0, ss_n)
        `CHK("timer clock high", 1'b1, tmr_clk)
        board(6'h30, 6'h3f);
        settle();
        `CHK("slave select high", 1'b1, ss_n)
        @(posedge clk);
        ss_en  <= 1'b0;
        tmr_en <= 1'b0;
        settle();
        `CHK("slave select idle", 1'b1, ss_n)
        `CHK("timer clock low", 1'b0, tmr_clk)
        done("peripherals");
        wr_reg(OFS_PIN_DATA, 8'h3f);
        @(posedge clk);
        other_rst <= 1'b1;
        @(posedge clk);
        other_rst <= 1'b0;
        #1;
        `CHK("other reset dir", 6'h00, pin_oe)
        rd_chk("other reset cfg", OFS_ANALOG_CFG, 8'h00);
        wr_reg(OFS_DIRECTION, 8'h00);
        #1;
        `CHK("bit4 kept", 6'h2f, pin_oe)
        `CHK("others cleared", 6'h00, pin_out)
        done("other reset");
        final_report();
    end
endmodule
